// ===== test_universal_serial_shift_unit.sv
/*
 * self-checking bench for the serial shift unit: apb master and scenarios.
 * assumes ussu_pkg, ussu_top and ussu_peer are compiled before it.
 */
`timescale 1ns/1ps

module test_universal_serial_shift_unit;
    localparam logic [11:0] AD = ussu_pkg::DATA_OFS;
    localparam logic [11:0] AS = ussu_pkg::STATUS_OFS;
    localparam logic [11:0] AC = ussu_pkg::CONTROL_OFS;
    localparam logic [11:0] AP = ussu_pkg::PORT_OFS;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic timer_match = 1'b0;
    logic sleep_idle = 1'b0;
    logic go = 1'b0;
    logic [7:0] peer_tx = 8'h00;
    logic sda_low = 1'b0;
    logic scl_low = 1'b0;
    logic shared = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err_bit, data_line, clk_line, peer_busy;
    logic data_pin_o, data_pin_oe, clk_pin_o, clk_pin_oe, start_irq, overflow_irq, wake_req;
    logic [7:0] peer_rx;
    int err_count = 0;
    int n_compared = 0;

    always #12.5 pclk = ~pclk;

    ussu_top ussu_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_match(timer_match),
        .sleep_idle(sleep_idle), .data_pin_i(data_line), .data_pin_o(data_pin_o),
        .data_pin_oe(data_pin_oe), .clk_pin_i(clk_line), .clk_pin_o(clk_pin_o),
        .clk_pin_oe(clk_pin_oe), .start_irq(start_irq), .overflow_irq(overflow_irq),
        .wake_req(wake_req));

    ussu_peer ussu_peer_i (.go(go), .tx(peer_tx), .sda_low(sda_low), .scl_low(scl_low),
        .shared(shared), .dut_do(data_pin_o), .dut_doe(data_pin_oe), .dut_co(clk_pin_o),
        .dut_coe(clk_pin_oe), .data_line(data_line), .clk_line(clk_line), .rx(peer_rx),
        .busy(peer_busy));

    // ****************************************
    // bus and compare helpers
    // ****************************************
    // entered just after a rising edge; request held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic tm);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        timer_match <= tm;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err_bit = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        timer_match <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, 1'b0);
        chk(rd & {24'h0, m}, {24'h0, exp});
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        rchk(AD, 8'hFF, 8'h00);
        rchk(AS, 8'hEF, 8'h00);
        rchk(AC, 8'hFF, 8'h00);
        rchk(AP, 8'hFF, 8'h00);
        rchk(12'h010, 8'hFF, 8'h00);
        chk1(err_bit, 1'b1);
        chk1(data_pin_oe, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_strobe;
        wr(AC, 8'h00);
        wr(AS, 8'hE0);
        wr(AD, 8'h81);
        wr(AC, 8'h02);
        rchk(AD, 8'hFF, 8'h03);
        rchk(AS, 8'hEF, 8'h01);
        rchk(AC, 8'hFF, 8'h00);
        $display("test strobe done");
    endtask

    task automatic t_timer;
        wr(AC, 8'h04);
        wr(AS, 8'hE0);
        wr(AD, 8'h40);
        timer_match <= 1'b1;
        @(posedge pclk);
        timer_match <= 1'b0;
        w(2);
        rchk(AD, 8'hFF, 8'h81);
        rchk(AS, 8'h0F, 8'h01);
        // write lands in the same cycle as a timer shift
        apb(1'b1, AD, 8'h5A, 1'b1);
        rchk(AD, 8'hFF, 8'h5A);
        rchk(AS, 8'h0F, 8'h02);
        $display("test timer done");
    endtask

    task automatic t_toggle;
        wr(AP, 8'h00);
        wr(AS, 8'hE0);
        wr(AC, 8'h0A);
        rchk(AC, 8'hFF, 8'h08);
        wr(AC, 8'h0B);
        rchk(AP, 8'h08, 8'h08);
        rchk(AS, 8'h0F, 8'h01);
        wr(AC, 8'h0B);
        rchk(AP, 8'h08, 8'h00);
        rchk(AS, 8'h0F, 8'h02);
        $display("test toggle done");
    endtask

    task automatic t_frame(input logic [7:0] ctl, input logic [7:0] ld, input logic [7:0] tx,
                           input logic [7:0] exp_rx, input logic oe);
        wr(AP, {7'h00, oe});
        wr(AC, ctl);
        wr(AS, 8'hE0);
        wr(AD, ld);
        peer_tx <= tx;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (peer_busy === 1'b1) @(posedge pclk);
        w(6);
        chk1(data_pin_oe, oe);
        rchk(AD, 8'hFF, tx);
        rchk(AS, 8'hEF, 8'hC0);
        if (oe) begin
            chk({24'h0, peer_rx}, {24'h0, exp_rx});
        end
        $display("test frame done");
    endtask

    task automatic t_ovf;
        wr(AP, 8'h0C);
        wr(AC, 8'h70);
        wr(AS, 8'hEF);
        wr(AC, 8'h72);
        rchk(AS, 8'hEF, 8'h40);
        chk1(overflow_irq, 1'b0);
        chk1(clk_line, 1'b0);
        wr(AP, 8'h1C);
        chk1(overflow_irq, 1'b1);
        chk1(wake_req, 1'b0);
        sleep_idle <= 1'b1;
        w(2);
        chk1(wake_req, 1'b1);
        sleep_idle <= 1'b0;
        wr(AS, 8'h40);
        chk1(overflow_irq, 1'b0);
        w(4);
        chk1(clk_line, 1'b1);
        rchk(AS, 8'hEF, 8'h00);
        $display("test overflow done");
    endtask

    task automatic t_two;
        shared <= 1'b1;
        wr(AP, 8'h1F);
        wr(AC, 8'hA0);
        wr(AD, 8'h80);
        wr(AS, 8'hE0);
        sda_low <= 1'b1;
        w(8);
        rchk(AS, 8'hB0, 8'h90);
        chk1(start_irq, 1'b1);
        chk1(wake_req, 1'b1);
        scl_low <= 1'b1;
        w(8);
        scl_low <= 1'b0;
        w(8);
        chk1(clk_line, 1'b0);
        wr(AS, 8'h80);
        w(4);
        chk1(clk_line, 1'b1);
        chk1(start_irq, 1'b0);
        sda_low <= 1'b0;
        w(8);
        rchk(AS, 8'hB0, 8'h20);
        chk1(start_irq, 1'b0);
        wr(AS, 8'h20);
        rchk(AS, 8'hB0, 8'h00);
        shared <= 1'b0;
        $display("test two-wire done");
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_strobe;
        t_timer;
        t_toggle;
        t_frame(8'h08, 8'hA5, 8'h3C, 8'h00, 1'b0);
        t_frame(8'h18, 8'hA5, 8'h3C, 8'hA5, 1'b1);
        t_frame(8'h1C, 8'h96, 8'h71, 8'h2C, 1'b1);
        t_ovf;
        t_two;
        conclude;
    end

    // about twenty-five times the expected run length
    initial begin
        #300000;
        err_count++;
        conclude;
    end
endmodule

// ===== ussu_peer.sv
/*
 * far-side serial master for the shift unit: drives the data and clock
 * lines, resolves open-drain pulls and samples the unit's data output.
 * assumes a 1ns time unit; the bench pulses go once per eight-bit frame.
 */
`timescale 1ns/1ps

module ussu_peer (
    input wire logic go,
    input wire logic [7:0] tx,
    input wire logic sda_low,
    input wire logic scl_low,
    input wire logic shared,
    input wire logic dut_do,
    input wire logic dut_doe,
    input wire logic dut_co,
    input wire logic dut_coe,
    output logic data_line,
    output logic clk_line,
    output logic [7:0] rx,
    output logic busy
);
    logic sck;
    logic sd;

    // ****************************************
    // lines
    // ****************************************
    // pull-ups: a released line rests high; an enabled low drive wins, the unit's data drive only when shared
    assign data_line = (busy ? sd : ~sda_low) & ~(shared & dut_doe & ~dut_do);
    assign clk_line = (busy ? sck : ~scl_low) & ~(dut_coe & ~dut_co);

    // ****************************************
    // frame
    // ****************************************
    // clock stands high between frames; 100 ns per level
    initial begin
        busy = 1'b0;
        sck = 1'b1;
        sd = 1'b1;
        rx = 8'h00;
        forever begin
            @(posedge go);
            busy = 1'b1;
            for (int i = 7; i >= 0; i--) begin
                sck = 1'b0;
                sd = tx[i];
                #100;
                sck = 1'b1;
                rx = {rx[6:0], dut_doe ? dut_do : ~rx[0]};
                #100;
            end
            busy = 1'b0;
        end
    end
endmodule

// ===== ussu_pkg.sv
/*
 * package for the universal serial shift unit: register offsets, field
 * positions, reset values and the carrier struct.
 * assumes a 32-bit apb slave with one register per aligned word.
 */
package ussu_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] DATA_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] CONTROL_OFS = 12'h008;
    localparam logic [11:0] PORT_OFS = 12'h00C;

    // ****************************************
    // field positions
    // ****************************************
    localparam int ST_START = 7;
    localparam int ST_OVF = 6;
    localparam int ST_STOP = 5;
    localparam int ST_COLL = 4;
    localparam int CT_SIE = 7;
    localparam int CT_OIE = 6;
    localparam int CT_CLK = 1;
    localparam int CT_TC = 0;
    localparam int PT_DO_DIR = 0;
    localparam int PT_DO_VAL = 1;
    localparam int PT_CK_DIR = 2;
    localparam int PT_CK_VAL = 3;
    localparam int PT_GIE = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [4:0] PORT_RST = 5'h00;

    // ****************************************
    // modes
    // ****************************************
    typedef enum logic [1:0] {
        USSU_WM_OFF = 2'h0,
        USSU_WM_THREE = 2'h1,
        USSU_WM_TWO = 2'h2,
        USSU_WM_TWO_HOLD = 2'h3
    } ussu_wire_mode_t;

    typedef struct packed {
        logic o;
        logic oe;
    } ussu_pin_drive_t;

endpackage

// ===== ussu_top.sv
/*
 * universal serial shift unit: shift register, 4-bit clock counter, flags,
 * output latch and pin drive, reached over apb.
 * assumes pins are asynchronous to pclk; the shift clock pin is sampled and
 * its edges found by pclk, so it must run well below pclk/4.
 */
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module ussu_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_match,
    input wire logic sleep_idle,
    input wire logic data_pin_i,
    output logic data_pin_o,
    output logic data_pin_oe,
    input wire logic clk_pin_i,
    output logic clk_pin_o,
    output logic clk_pin_oe,
    output logic start_irq,
    output logic overflow_irq,
    output logic wake_req
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] din_sync;
    logic [1:0] ck_sync;
    logic ck_prev;
    logic din_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_sync <= 2'h3;
            ck_sync <= 2'h3;
            ck_prev <= 1'b1;
            din_prev <= 1'b1;
        end else begin
            din_sync <= {din_sync[0], data_pin_i};
            ck_sync <= {ck_sync[0], clk_pin_i};
            ck_prev <= ck_sync[1];
            din_prev <= din_sync[1];
        end
    end

    wire din_s = din_sync[1];
    wire ck_s = ck_sync[1];
    wire ck_rise = ck_s & ~ck_prev;
    wire ck_fall = ~ck_s & ck_prev;
    wire ck_any = ck_rise | ck_fall;

    // ****************************************
    // registers and bus decode
    // ****************************************
    logic [7:0] shift_data_reg;
    logic [3:0] clock_counter_value;
    logic start_cond_flag;
    logic counter_overflow_flag;
    logic stop_cond_flag;
    logic [7:0] serial_control_reg;
    logic [4:0] port_reg;
    logic out_latch;

    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire lane0 = pstrb[0];
    wire hit_data = paddr == ussu_pkg::DATA_OFS;
    wire hit_stat = paddr == ussu_pkg::STATUS_OFS;
    wire hit_ctrl = paddr == ussu_pkg::CONTROL_OFS;
    wire hit_port = paddr == ussu_pkg::PORT_OFS;
    wire hit_any = hit_data | hit_stat | hit_ctrl | hit_port;
    wire wr_data = wr & hit_data & lane0;
    wire wr_stat = wr & hit_stat & lane0;
    wire wr_ctrl = wr & hit_ctrl & lane0;
    wire wr_port = wr & hit_port & lane0;

    wire [1:0] wire_mode_sel = serial_control_reg[5:4];
    wire [1:0] clock_source_sel = serial_control_reg[3:2];
    wire strobe_sel = serial_control_reg[ussu_pkg::CT_CLK];
    wire two_wire = wire_mode_sel[1];
    wire ext_clk = clock_source_sel[1];
    // strobe bits act on the write; bit 0 never stored, bit 1 kept as strobe select only with an external source
    wire clock_strobe_bit = wr_ctrl & pwdata[ussu_pkg::CT_CLK];
    wire clock_toggle_strobe = wr_ctrl & pwdata[ussu_pkg::CT_TC];

    // ****************************************
    // clock source selection
    // ****************************************
    // shift event select
    wire shift_ev = (clock_source_sel == 2'h0) ? clock_strobe_bit :
                    (clock_source_sel == 2'h1) ? timer_match :
                    (clock_source_sel == 2'h2) ? ck_rise : ck_fall;
    wire count_ev = (clock_source_sel == 2'h0) ? clock_strobe_bit :
                    (clock_source_sel == 2'h1) ? timer_match :
                    (strobe_sel ? clock_toggle_strobe : ck_any);

    // ****************************************
    // shift register
    // ****************************************
    // write wins over shift; pins used in every mode
    wire [7:0] next_shift = wr_data ? pwdata[7:0] :
                            shift_ev ? {shift_data_reg[6:0], din_s} : shift_data_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_data_reg <= ussu_pkg::DATA_RST;
        end else begin
            shift_data_reg <= next_shift;
        end
    end

    // ****************************************
    // counter
    // ****************************************
    // cpu write wins over count
    wire cnt_wrap = count_ev & (clock_counter_value == 4'hF) & ~wr_stat;
    wire [3:0] next_cnt = wr_stat ? pwdata[3:0] :
                          count_ev ? clock_counter_value + 4'h1 : clock_counter_value;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_counter_value <= ussu_pkg::CNT_RST;
        end else begin
            clock_counter_value <= next_cnt;
        end
    end

    // ****************************************
    // start and stop detection
    // ****************************************
    // data delayed one sample so clock level is valid at data edge
    // two-wire start: data falls, clock high
    wire tw_start = two_wire & ~din_s & din_prev & ck_s;
    // two-wire stop: data rises, clock high
    wire tw_stop = two_wire & din_s & ~din_prev & ck_s;
    wire edge_start = ~two_wire & ext_clk & ~strobe_sel & ck_any;
    wire start_set = tw_start | edge_start;

    // ****************************************
    // flags (set wins over clear)
    // ****************************************
    // start flag clear by one
    wire next_start = start_set | (start_cond_flag &
                      ~(wr_stat & pwdata[ussu_pkg::ST_START]));
    wire next_ovf = cnt_wrap | (counter_overflow_flag &
                    ~(wr_stat & pwdata[ussu_pkg::ST_OVF]));
    wire next_stop = tw_stop | (stop_cond_flag &
                     ~(wr_stat & pwdata[ussu_pkg::ST_STOP]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_cond_flag <= 1'b0;
            counter_overflow_flag <= 1'b0;
            stop_cond_flag <= 1'b0;
        end else begin
            start_cond_flag <= next_start;
            counter_overflow_flag <= next_ovf;
            stop_cond_flag <= next_stop;
        end
    end

    // ****************************************
    // control and port registers
    // ****************************************
    // toggle inverts clock port value
    wire [4:0] port_wr = wr_port ? pwdata[4:0] : port_reg;
    wire [4:0] next_port = clock_toggle_strobe ?
                           (port_wr ^ (5'h01 << ussu_pkg::PT_CK_VAL)) : port_wr;
    // strobe select kept only with an external source
    wire [7:0] ctrl_wr = {pwdata[7:2], pwdata[ussu_pkg::CT_CLK] & pwdata[3], 1'b0};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_reg <= ussu_pkg::CTRL_RST;
            port_reg <= ussu_pkg::PORT_RST;
        end else begin
            if (wr_ctrl) begin
                serial_control_reg <= ctrl_wr;
            end
            port_reg <= next_port;
        end
    end

    // ****************************************
    // output latch
    // ****************************************
    // first half of the serial clock is taken as clock low (after the
    // falling edge); the latch then holds through the high half.
    // latch transparency
    wire latch_open = ~ext_clk | ~ck_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_latch <= 1'b0;
        end else if (latch_open) begin
            out_latch <= next_shift[7];
        end
    end

    // ****************************************
    // pin drive
    // ****************************************
    wire do_dir = port_reg[ussu_pkg::PT_DO_DIR];
    wire do_val = port_reg[ussu_pkg::PT_DO_VAL];
    wire ck_dir = port_reg[ussu_pkg::PT_CK_DIR];
    wire ck_val = port_reg[ussu_pkg::PT_CK_VAL];
    wire clk_hold = two_wire & (start_cond_flag |
                    ((wire_mode_sel == 2'h3) & counter_overflow_flag));
    ussu_pkg::ussu_pin_drive_t dpin;
    ussu_pkg::ussu_pin_drive_t cpin;

    always_comb begin
        case (wire_mode_sel)
            2'h1: begin
                dpin = '{o: out_latch, oe: do_dir};
                cpin = '{o: ck_val, oe: ck_dir};
            end
            2'h2, 2'h3: begin
                dpin = '{o: 1'b0, oe: do_dir & ~(out_latch & do_val)};
                cpin = '{o: 1'b0, oe: ck_dir & (~ck_val | clk_hold)};
            end
            default: begin
                dpin = '{o: do_val, oe: do_dir};
                cpin = '{o: ck_val, oe: ck_dir};
            end
        endcase
    end

    assign data_pin_o = dpin.o;
    assign data_pin_oe = dpin.oe;
    assign clk_pin_o = cpin.o;
    assign clk_pin_oe = cpin.oe;

    // ****************************************
    // interrupts and wake
    // ****************************************
    wire gie = port_reg[ussu_pkg::PT_GIE];
    assign start_irq = start_cond_flag & serial_control_reg[ussu_pkg::CT_SIE] & gie;
    assign overflow_irq = counter_overflow_flag & serial_control_reg[ussu_pkg::CT_OIE] & gie;
    assign wake_req = start_irq | (overflow_irq & sleep_idle);

    // ****************************************
    // read back
    // ****************************************
    // collision against sensed pin
    wire data_collision_bit = shift_data_reg[7] ^ din_s;
    wire [7:0] serial_status_reg = {start_cond_flag, counter_overflow_flag,
                                    stop_cond_flag, data_collision_bit, clock_counter_value};
    wire [7:0] rd_mux = hit_data ? shift_data_reg :
                        hit_stat ? serial_status_reg :
                        hit_ctrl ? {serial_control_reg[7:2], 2'h0} :
                        hit_port ? {3'h0, port_reg} : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= {24'h00_0000, rd_mux};
        end
    end

    assign pready = 1'b1;
    assign pslverr = acc & ~hit_any;

    // ****************************************
    // checks
    // ****************************************
    a_write_beats_shift: assert property (@(posedge pclk) disable iff (!presetn)
        wr_data |=> shift_data_reg == $past(pwdata[7:0]))
        else $error("data write lost");
    a_shift_left: assert property (@(posedge pclk) disable iff (!presetn)
        (shift_ev & ~wr_data) |=> shift_data_reg[7:1] == $past(shift_data_reg[6:0]))
        else $error("shift wrong");
    a_wrap_sets_ovf: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_wrap |=> counter_overflow_flag && clock_counter_value == 4'h0)
        else $error("overflow not set");
    a_start_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (start_cond_flag & ~start_set & ~(wr_stat & pwdata[7])) |=> start_cond_flag)
        else $error("start flag lost");
    a_count_inc: assert property (@(posedge pclk) disable iff (!presetn)
        (count_ev & ~wr_stat) |=> clock_counter_value == $past(clock_counter_value) + 4'h1)
        else $error("count wrong");
    a_hold_mode3: assert property (@(posedge pclk) disable iff (!presetn)
        (wire_mode_sel == 2'h3 && counter_overflow_flag && ck_dir) |-> clk_pin_oe)
        else $error("clock not held");
    a_no_drive_dir: assert property (@(posedge pclk) disable iff (!presetn)
        ~do_dir |-> ~data_pin_oe)
        else $error("data driven without dir");
    a_toggle_inv: assert property (@(posedge pclk) disable iff (!presetn)
        (clock_toggle_strobe & ~wr_port) |=> ck_val != $past(ck_val))
        else $error("toggle failed");
    a_ovf_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (counter_overflow_flag & ~cnt_wrap & ~(wr_stat & pwdata[6])) |=> counter_overflow_flag)
        else $error("overflow flag lost");
    a_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (stop_cond_flag & ~tw_stop & ~(wr_stat & pwdata[5])) |=> stop_cond_flag)
        else $error("stop flag lost");
    a_two_start: assert property (@(posedge pclk) disable iff (!presetn)
        tw_start |=> start_cond_flag)
        else $error("two-wire start missed");
    a_edge_start: assert property (@(posedge pclk) disable iff (!presetn)
        edge_start |=> start_cond_flag)
        else $error("edge start missed");
    a_timer_count: assert property (@(posedge pclk) disable iff (!presetn)
        (clock_source_sel == 2'h1 && timer_match && !wr_stat) |=>
        clock_counter_value == $past(clock_counter_value) + 4'h1)
        else $error("timer count missed");
    a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_clk && ck_s) |=> out_latch == $past(out_latch))
        else $error("latch not held");
    a_latch_open: assert property (@(posedge pclk) disable iff (!presetn)
        !ext_clk |=> out_latch == shift_data_reg[7])
        else $error("latch not transparent");
    a_toggle_count: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_clk && strobe_sel && !clock_toggle_strobe && !wr_stat) |=>
        $stable(clock_counter_value))
        else $error("count without toggle");
    a_wake_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (!start_irq && !sleep_idle) |-> !wake_req)
        else $error("wake outside idle");
    a_status_load: assert property (@(posedge pclk) disable iff (!presetn)
        wr_stat |=> clock_counter_value == $past(pwdata[3:0]))
        else $error("counter load lost");
    a_two_data_low: assert property (@(posedge pclk) disable iff (!presetn)
        (two_wire && do_dir && !out_latch) |-> (data_pin_oe && !data_pin_o))
        else $error("data line not pulled");

endmodule
